// ===== shared/crf_pkg.sv
// Constants and state layout for the processor register file
package crf_pkg;

	// Widths
	localparam int WORD_W  = 16;
	localparam int BYTE_W  = 8;
	localparam int LONG_W  = 32;
	localparam int ADDR20_W = 20;
	localparam int FLAG_W  = 11;
	localparam int REG_IDX_W = 5;
	localparam int BANKS   = 2;
	localparam int NDATA   = 4;

	// Register indices on the access port
	localparam logic [4:0] IDX_DATA0  = 5'h00;
	localparam logic [4:0] IDX_DATA1  = 5'h01;
	localparam logic [4:0] IDX_DATA2  = 5'h02;
	localparam logic [4:0] IDX_DATA3  = 5'h03;
	localparam logic [4:0] IDX_D0_HI  = 5'h04;
	localparam logic [4:0] IDX_D0_LO  = 5'h05;
	localparam logic [4:0] IDX_D1_HI  = 5'h06;
	localparam logic [4:0] IDX_D1_LO  = 5'h07;
	localparam logic [4:0] IDX_PAIR_LO = 5'h08;
	localparam logic [4:0] IDX_PAIR_HI = 5'h09;
	localparam logic [4:0] IDX_ADDR0  = 5'h0A;
	localparam logic [4:0] IDX_ADDR1  = 5'h0B;
	localparam logic [4:0] IDX_ADDR_PAIR = 5'h0C;
	localparam logic [4:0] IDX_FRAME  = 5'h0D;
	localparam logic [4:0] IDX_STATIC = 5'h0E;
	localparam logic [4:0] IDX_VECTOR = 5'h0F;
	localparam logic [4:0] IDX_PC     = 5'h10;
	localparam logic [4:0] IDX_SP     = 5'h11;
	localparam logic [4:0] IDX_USER_SP = 5'h12;
	localparam logic [4:0] IDX_IRQ_SP  = 5'h13;
	localparam logic [4:0] IDX_FLAGS  = 5'h14;

	// Flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_D = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_S = 3;
	localparam int FLAG_B = 4;
	localparam int FLAG_O = 5;
	localparam int FLAG_I = 6;
	localparam int FLAG_U = 7;

	// Operand size of an arithmetic result
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	// Reset values
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [19:0] RST_ADDR20 = 20'h0_0000;
	localparam logic [10:0] RST_FLAGS = 11'h000;
	localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

	typedef struct packed {
		logic [BANKS-1:0][NDATA-1:0][WORD_W-1:0] dreg;
		logic [BANKS-1:0][1:0][WORD_W-1:0]       areg;
		logic [BANKS-1:0][WORD_W-1:0]            frame;
		logic [WORD_W-1:0]                       stat_base;
		logic [ADDR20_W-1:0]                     vec_base;
		logic [ADDR20_W-1:0]                     pc;
		logic [WORD_W-1:0]                       user_sp;
		logic [WORD_W-1:0]                       irq_sp;
		logic [FLAG_W-1:0]                       flags;
		logic [WORD_W-1:0]                       act_sp;
		logic [WORD_W-1:0]                       act_frame;
		logic [LONG_W-1:0]                       act_apair;
		logic [LONG_W-1:0]                       rdata;
	} crf_state_t;

endpackage : crf_pkg

// ===== src/crf_register_file.sv
// Programmer-visible register file of the processor core
//
// Function
// - Four 16-bit data registers, readable and writable as operands.
// - Data registers 0 and 1 have separately writable high and low bytes.
// - Data 2:0 and data 3:1 act as 32-bit pairs.
// - Two 16-bit address registers, usable as base and operand.
// - Address 1:0 form one 32-bit register, address 1 upper.
// - 16-bit frame base register for frame-relative addressing.
// - 20-bit vector table base register.
// - 20-bit program counter holding the next instruction address.
// - Two 16-bit stack pointers, stack select flag picks the active one.
// - 16-bit static base register.
// - 11-bit flag register showing the processor state.
// - Carry flag takes carry, borrow or shift-out from the ALU.
// - Zero flag is 1 for a zero result, else 0.
// - Sign flag is 1 for a negative result, else 0.
// - Bank flag selects which bank all banked accesses reach.
// - Overflow flag is 1 on overflow, else 0.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

module crf_register_file
	import crf_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 resetn_i,
	input  wire logic [REG_IDX_W-1:0] addr_i,
	input  wire logic [LONG_W-1:0]    wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	input  wire logic                 alu_upd_i,
	input  wire logic [LONG_W-1:0]    alu_result_i,
	input  wire logic [1:0]           alu_size_i,
	input  wire logic                 alu_carry_i,
	input  wire logic                 alu_ovf_i,
	input  wire logic                 pc_adv_i,
	input  wire logic [2:0]           pc_step_i,
	output logic      [LONG_W-1:0]    rdata_o,
	output logic      [FLAG_W-1:0]    flags_o,
	output logic      [ADDR20_W-1:0]  pc_o,
	output logic      [WORD_W-1:0]    active_sp_o,
	output logic      [ADDR20_W-1:0]  vector_base_o,
	output logic      [WORD_W-1:0]    frame_base_o,
	output logic      [WORD_W-1:0]    static_base_o,
	output logic      [LONG_W-1:0]    addr_pair_o
);

	crf_state_t st_reg;
	crf_state_t st_next;
	logic       bank;
	logic       res_zero;
	logic       res_neg;

	////////////////////////////////////////////////////////////////////////
	// Result classification for the condition flags

	always_comb begin
		res_zero = 1'b0;
		res_neg  = 1'b0;
		case (alu_size_i)
			SZ_BYTE: begin
				res_zero = (alu_result_i[BYTE_W-1:0] == '0);
				res_neg  = alu_result_i[BYTE_W-1];
			end
			SZ_WORD: begin
				res_zero = (alu_result_i[WORD_W-1:0] == '0);
				res_neg  = alu_result_i[WORD_W-1];
			end
			default: begin
				res_zero = (alu_result_i == '0);
				res_neg  = alu_result_i[LONG_W-1];
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		st_next = st_reg;
		bank = st_reg.flags[FLAG_B];

		if (wr_i) begin
			if (addr_i <= IDX_DATA3) begin
				st_next.dreg[bank][addr_i[1:0]] = wdata_i[WORD_W-1:0];
			end else if (addr_i == IDX_D0_HI) begin
				st_next.dreg[bank][0][WORD_W-1:BYTE_W] = wdata_i[BYTE_W-1:0];
			end else if (addr_i == IDX_D0_LO) begin
				st_next.dreg[bank][0][BYTE_W-1:0] = wdata_i[BYTE_W-1:0];
			end else if (addr_i == IDX_D1_HI) begin
				st_next.dreg[bank][1][WORD_W-1:BYTE_W] = wdata_i[BYTE_W-1:0];
			end else if (addr_i == IDX_D1_LO) begin
				st_next.dreg[bank][1][BYTE_W-1:0] = wdata_i[BYTE_W-1:0];
			end else if (addr_i == IDX_PAIR_LO) begin
				st_next.dreg[bank][2] = wdata_i[LONG_W-1:WORD_W];
				st_next.dreg[bank][0] = wdata_i[WORD_W-1:0];
			end else if (addr_i == IDX_PAIR_HI) begin
				st_next.dreg[bank][3] = wdata_i[LONG_W-1:WORD_W];
				st_next.dreg[bank][1] = wdata_i[WORD_W-1:0];
			end else if (addr_i == IDX_ADDR0) begin
				st_next.areg[bank][0] = wdata_i[WORD_W-1:0];
			end else if (addr_i == IDX_ADDR1) begin
				st_next.areg[bank][1] = wdata_i[WORD_W-1:0];
			end else if (addr_i == IDX_ADDR_PAIR) begin
				st_next.areg[bank][1] = wdata_i[LONG_W-1:WORD_W];
				st_next.areg[bank][0] = wdata_i[WORD_W-1:0];
			end else if (addr_i == IDX_FRAME) begin
				st_next.frame[bank] = wdata_i[WORD_W-1:0];
			end else if (addr_i == IDX_STATIC) begin
				st_next.stat_base = wdata_i[WORD_W-1:0];
			end else if (addr_i == IDX_VECTOR) begin
				st_next.vec_base = wdata_i[ADDR20_W-1:0];
			end else if (addr_i == IDX_PC) begin
				st_next.pc = wdata_i[ADDR20_W-1:0];
			end else if (addr_i == IDX_SP) begin
				if (st_reg.flags[FLAG_U]) begin
					st_next.user_sp = wdata_i[WORD_W-1:0];
				end else begin
					st_next.irq_sp = wdata_i[WORD_W-1:0];
				end
			end else if (addr_i == IDX_USER_SP) begin
				st_next.user_sp = wdata_i[WORD_W-1:0];
			end else if (addr_i == IDX_IRQ_SP) begin
				st_next.irq_sp = wdata_i[WORD_W-1:0];
			// whole flag register write; debug bit stored as given
			end else if (addr_i == IDX_FLAGS) begin
				st_next.flags = wdata_i[FLAG_W-1:0];
			end
		end

		// advance to next instruction; a direct load wins over a step
		if (pc_adv_i && !(wr_i && addr_i == IDX_PC)) begin
			st_next.pc = st_reg.pc + ADDR20_W'(pc_step_i);
		end

		// Condition flags from the ALU win over a same-cycle software write
		if (alu_upd_i) begin
			st_next.flags[FLAG_C] = alu_carry_i;
			st_next.flags[FLAG_Z] = res_zero;
			st_next.flags[FLAG_S] = res_neg;
			st_next.flags[FLAG_O] = alu_ovf_i;
		end

		// registered copy of the active stack pointer
		st_next.act_sp = st_next.flags[FLAG_U] ? st_next.user_sp : st_next.irq_sp;
		// selected frame base
		// Registered so the bank mux never sits between a flop and the pin
		st_next.act_frame = st_next.frame[st_next.flags[FLAG_B]];
		st_next.act_apair = {st_next.areg[st_next.flags[FLAG_B]][1], st_next.areg[st_next.flags[FLAG_B]][0]};

		// Read data stands in the cycle after the strobe only
		st_next.rdata = RD_ZERO;
		if (rd_i) begin
			if (addr_i <= IDX_DATA3) begin
				st_next.rdata = LONG_W'(st_reg.dreg[bank][addr_i[1:0]]);
			end else if (addr_i == IDX_D0_HI) begin
				st_next.rdata = LONG_W'(st_reg.dreg[bank][0][WORD_W-1:BYTE_W]);
			end else if (addr_i == IDX_D0_LO) begin
				st_next.rdata = LONG_W'(st_reg.dreg[bank][0][BYTE_W-1:0]);
			end else if (addr_i == IDX_D1_HI) begin
				st_next.rdata = LONG_W'(st_reg.dreg[bank][1][WORD_W-1:BYTE_W]);
			end else if (addr_i == IDX_D1_LO) begin
				st_next.rdata = LONG_W'(st_reg.dreg[bank][1][BYTE_W-1:0]);
			end else if (addr_i == IDX_PAIR_LO) begin
				st_next.rdata = {st_reg.dreg[bank][2], st_reg.dreg[bank][0]};
			end else if (addr_i == IDX_PAIR_HI) begin
				st_next.rdata = {st_reg.dreg[bank][3], st_reg.dreg[bank][1]};
			end else if (addr_i == IDX_ADDR0) begin
				st_next.rdata = LONG_W'(st_reg.areg[bank][0]);
			end else if (addr_i == IDX_ADDR1) begin
				st_next.rdata = LONG_W'(st_reg.areg[bank][1]);
			end else if (addr_i == IDX_ADDR_PAIR) begin
				st_next.rdata = {st_reg.areg[bank][1], st_reg.areg[bank][0]};
			end else if (addr_i == IDX_FRAME) begin
				st_next.rdata = LONG_W'(st_reg.frame[bank]);
			end else if (addr_i == IDX_STATIC) begin
				st_next.rdata = LONG_W'(st_reg.stat_base);
			end else if (addr_i == IDX_VECTOR) begin
				st_next.rdata = LONG_W'(st_reg.vec_base);
			end else if (addr_i == IDX_PC) begin
				st_next.rdata = LONG_W'(st_reg.pc);
			end else if (addr_i == IDX_SP) begin
				st_next.rdata = LONG_W'(st_reg.act_sp);
			end else if (addr_i == IDX_USER_SP) begin
				st_next.rdata = LONG_W'(st_reg.user_sp);
			end else if (addr_i == IDX_IRQ_SP) begin
				st_next.rdata = LONG_W'(st_reg.irq_sp);
			end else if (addr_i == IDX_FLAGS) begin
				st_next.rdata = LONG_W'(st_reg.flags);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg.dreg   <= '0;
			st_reg.areg   <= '0;
			st_reg.frame     <= '0;
			st_reg.stat_base <= RST_WORD;
			st_reg.vec_base  <= RST_ADDR20;
			st_reg.pc        <= RST_ADDR20;
			st_reg.user_sp   <= RST_WORD;
			st_reg.irq_sp    <= RST_WORD;
			st_reg.flags     <= RST_FLAGS;
			st_reg.act_sp    <= RST_WORD;
			st_reg.act_frame <= RST_WORD;
			st_reg.act_apair <= RD_ZERO;
			st_reg.rdata  <= RD_ZERO;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from state flip-flops

	assign rdata_o       = st_reg.rdata;
	assign flags_o       = st_reg.flags;
	assign pc_o          = st_reg.pc;
	assign active_sp_o   = st_reg.act_sp;
	assign vector_base_o = st_reg.vec_base;
	assign frame_base_o  = st_reg.act_frame;
	assign static_base_o = st_reg.stat_base;
	assign addr_pair_o   = st_reg.act_apair;

endmodule : crf_register_file

// ===== verification/crf_alu_model.sv
// Arithmetic unit model that feeds the flag inputs
`timescale 1ns/100ps
module crf_alu_model
	import crf_pkg::*;
(
	input  wire logic [LONG_W-1:0] a_i,
	input  wire logic [LONG_W-1:0] b_i,
	input  wire logic [1:0]        size_i,
	output logic      [LONG_W-1:0] result_o,
	output logic                   carry_o,
	output logic                   ovf_o
);
	logic [LONG_W-1:0] m;
	logic [LONG_W:0]   s;
	int                w;
	// Add only: enough to reach all four condition flags the ALU updates
	always_comb begin
		w = (size_i == SZ_BYTE) ? 8 : (size_i == SZ_WORD) ? 16 : 32;
		m = 32'hFFFF_FFFF >> (32 - w);
		s = {1'b0, a_i & m} + {1'b0, b_i & m};
		result_o = s[LONG_W-1:0] & m;
		carry_o = s[w];
		ovf_o = (a_i[w-1] == b_i[w-1]) && (s[w-1] != a_i[w-1]);
	end
endmodule : crf_alu_model

// ===== verification/crf_register_file_chk.sv
// Port checker for the register file
`timescale 1ns/100ps
module crf_register_file_chk
	import crf_pkg::*;
(
	input wire logic                 clk_i,
	input wire logic                 resetn_i,
	input wire logic [REG_IDX_W-1:0] addr_i,
	input wire logic [LONG_W-1:0]    wdata_i,
	input wire logic                 wr_i,
	input wire logic                 rd_i,
	input wire logic                 alu_upd_i,
	input wire logic [LONG_W-1:0]    alu_result_i,
	input wire logic [1:0]           alu_size_i,
	input wire logic                 alu_carry_i,
	input wire logic                 alu_ovf_i,
	input wire logic                 pc_adv_i,
	input wire logic [2:0]           pc_step_i,
	input wire logic [LONG_W-1:0]    rdata_o,
	input wire logic [FLAG_W-1:0]    flags_o,
	input wire logic [ADDR20_W-1:0]  pc_o,
	input wire logic [ADDR20_W-1:0]  vector_base_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	property p_rd_idle; !rd_i |=> rdata_o == RD_ZERO; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
	property p_pc_adv; pc_adv_i && !wr_i |=> pc_o == 20'($past(pc_o) + $past(pc_step_i)); endproperty
	a_pc_adv: assert property (p_pc_adv) else $error("pc step wrong");
	property p_pc_hold; !pc_adv_i && !wr_i |=> $stable(pc_o); endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("pc moved");
	property p_vec_hold; !wr_i |=> $stable(vector_base_o); endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector base moved");
	property p_carry; alu_upd_i |=> flags_o[FLAG_C] == $past(alu_carry_i); endproperty
	a_carry: assert property (p_carry) else $error("carry flag wrong");
	property p_zero; alu_upd_i && alu_size_i == SZ_BYTE |=> flags_o[FLAG_Z] == ($past(alu_result_i[7:0]) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_sign; alu_upd_i && alu_size_i == SZ_WORD |=> flags_o[FLAG_S] == $past(alu_result_i[15]); endproperty
	a_sign: assert property (p_sign) else $error("sign flag wrong");
	property p_ovf; alu_upd_i |=> flags_o[FLAG_O] == $past(alu_ovf_i); endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
	property p_bank; wr_i && addr_i == IDX_FLAGS |=> flags_o[FLAG_B] == $past(wdata_i[FLAG_B]); endproperty
	a_bank: assert property (p_bank) else $error("bank flag wrong");
endmodule : crf_register_file_chk

bind crf_register_file crf_register_file_chk crf_register_file_chk_i (.clk_i(clk_i), .resetn_i(resetn_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .alu_upd_i(alu_upd_i), .alu_result_i(alu_result_i),
	.alu_size_i(alu_size_i), .alu_carry_i(alu_carry_i), .alu_ovf_i(alu_ovf_i), .pc_adv_i(pc_adv_i),
	.pc_step_i(pc_step_i), .rdata_o(rdata_o), .flags_o(flags_o), .pc_o(pc_o), .vector_base_o(vector_base_o));

// ===== verification/tb.sv
// Self-checking testbench for the register file
`timescale 1ns/100ps
module tb;
	import crf_pkg::*;
	logic        clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, alu_upd_i = 0, pc_adv_i = 0;
	logic [4:0]  addr_i = '0;
	logic [31:0] wdata_i = '0, op_a = '0, op_b = '0;
	logic [1:0]  alu_size_i = '0;
	logic [2:0]  pc_step_i = '0;
	wire  [31:0] alu_result_i, rdata_o, addr_pair_o;
	wire         alu_carry_i, alu_ovf_i;
	wire  [10:0] flags_o;
	wire  [19:0] pc_o, vector_base_o;
	wire  [15:0] active_sp_o, frame_base_o, static_base_o;
	int          num_errors = 0, comparisons = 0;
	always #5 clk_i = ~clk_i;
	crf_register_file crf_register_file_i (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .alu_upd_i(alu_upd_i), .alu_result_i(alu_result_i), .alu_size_i(alu_size_i),
		.alu_carry_i(alu_carry_i), .alu_ovf_i(alu_ovf_i), .pc_adv_i(pc_adv_i), .pc_step_i(pc_step_i),
		.rdata_o(rdata_o), .flags_o(flags_o), .pc_o(pc_o), .active_sp_o(active_sp_o), .vector_base_o(vector_base_o),
		.frame_base_o(frame_base_o), .static_base_o(static_base_o), .addr_pair_o(addr_pair_o));
	crf_alu_model crf_alu_model_i (.a_i(op_a), .b_i(op_b), .size_i(alu_size_i), .result_o(alu_result_i),
		.carry_o(alu_carry_i), .ovf_o(alu_ovf_i));
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_i); addr_i <= a; wdata_i <= d; wr_i <= 1;
		@(posedge clk_i); wr_i <= 0;
		@(negedge clk_i);
	endtask : wr
	task rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge clk_i); addr_i <= a; rd_i <= 1;
		@(posedge clk_i); rd_i <= 0;
		@(negedge clk_i); chk(rdata_o, e);
	endtask : rd
	task alu(input logic [31:0] a, input logic [31:0] b, input logic [1:0] sz);
		@(posedge clk_i); op_a <= a; op_b <= b; alu_size_i <= sz; alu_upd_i <= 1;
		@(posedge clk_i); alu_upd_i <= 0;
		@(negedge clk_i);
	endtask : alu
	task end_sim;
		$display("Comparisons %0d, errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////
	// Whole run is under a hundred cycles, so this only catches a hang
	initial begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		end_sim;
	end
	initial begin
		repeat (3) @(posedge clk_i);
		resetn_i <= 1;
		@(negedge clk_i); chk(32'(flags_o), 0); chk(32'(pc_o), 0);
		for (int i = 0; i < 4; i++) wr(5'(i), 32'hFFFF_A5A0 + i);
		for (int i = 0; i < 4; i++) rd(5'(i), 32'h0000_A5A0 + i);
		wr(IDX_D0_HI, 32'h0000_3C77);
		wr(IDX_D1_LO, 32'h0000_0055);
		rd(IDX_DATA0, 32'h0000_77A0);
		rd(IDX_D1_LO, 32'h0000_0055);
		rd(IDX_PAIR_LO, 32'hA5A2_77A0);
		rd(IDX_PAIR_HI, 32'hA5A3_A555);
		wr(IDX_PAIR_HI, 32'h1357_9BDF);
		rd(IDX_D1_HI, 32'h0000_009B);
		rd(IDX_DATA3, 32'h0000_1357);
		wr(IDX_ADDR_PAIR, 32'h1234_5678);
		rd(IDX_ADDR1, 32'h0000_1234); chk(addr_pair_o, 32'h1234_5678);
		rd(IDX_ADDR0, 32'h0000_5678);
		$display("test data and address done");
		wr(IDX_FLAGS, 32'h0000_0010); wr(IDX_DATA0, 32'h0000_9999); wr(IDX_FRAME, 32'h0000_BEEF);
		rd(IDX_DATA0, 32'h0000_9999); chk(32'(frame_base_o), 32'h0000_BEEF);
		wr(IDX_FLAGS, 32'h0000_0000); rd(IDX_DATA0, 32'h0000_77A0); chk(32'(frame_base_o), 0);
		wr(IDX_STATIC, 32'hFFFF_1357); chk(32'(static_base_o), 32'h0000_1357);
		wr(IDX_VECTOR, 32'hFFFF_FFFF); rd(IDX_VECTOR, 32'h000F_FFFF);
		chk(32'(vector_base_o), 32'h000F_FFFF);
		$display("test banks and bases done");
		wr(IDX_USER_SP, 32'h0000_1111); wr(IDX_IRQ_SP, 32'h0000_2222); chk(32'(active_sp_o), 32'h0000_2222);
		wr(IDX_FLAGS, 32'h0000_0080); chk(32'(active_sp_o), 32'h0000_1111);
		rd(IDX_SP, 32'h0000_1111);
		rd(IDX_IRQ_SP, 32'h0000_2222);
		wr(IDX_PC, 32'h000F_FFFE);
		@(posedge clk_i); pc_adv_i <= 1; pc_step_i <= 3'h3;
		@(posedge clk_i); pc_adv_i <= 0;
		@(negedge clk_i); chk(32'(pc_o), 32'h0000_0001);
		rd(IDX_PC, 32'h0000_0001);
		$display("test stacks and pc done");
		// Debug flag stays clear in every flag write
		wr(IDX_FLAGS, 32'h0000_0000);
		alu(32'h0000_00FF, 32'h0000_0001, SZ_BYTE); chk(32'(flags_o), 32'h0000_0005);
		alu(32'h0000_7FFF, 32'h0000_0001, SZ_WORD); chk(32'(flags_o), 32'h0000_0028);
		alu(32'h8000_0000, 32'h8000_0000, SZ_LONG); chk(32'(flags_o), 32'h0000_0025);
		rd(IDX_FLAGS, 32'h0000_0025);
		rd(5'h1F, 32'h0000_0000);
		$display("test flags done");
		end_sim;
	end
endmodule : tb
